/* File: common/otp_pagebuf_pkg.sv */
// constants, types and decode helpers for the otp area and page buffer command block
`default_nettype none
package otp_pagebuf_pkg;
	// system clock period and default self-timed operation lengths
	localparam int CLK_PERIOD_NS                 = 10;
	localparam int DEF_PAGE_TRANSFER_TIME_NS     = 200000;
	localparam int DEF_PAGE_COMPARE_TIME_NS      = 200000;
	localparam int DEF_PAGE_REWRITE_TIME_NS      = 20000000;
	localparam int DEF_PROGRAM_TIME_NS           = 4000000;

	// command opcodes
	localparam logic [7:0] OP_OTP_PROG = 8'h9B;
	localparam logic [7:0] OP_OTP_READ = 8'h77;
	localparam logic [7:0] OP_XFR_B1   = 8'h53;
	localparam logic [7:0] OP_XFR_B2   = 8'h55;
	localparam logic [7:0] OP_CMP_B1   = 8'h60;
	localparam logic [7:0] OP_CMP_B2   = 8'h61;
	localparam logic [7:0] OP_RW_B1    = 8'h58;
	localparam logic [7:0] OP_RW_B2    = 8'h59;
	localparam logic [7:0] OP_STATUS   = 8'hD7;

	// array geometry
	localparam int SEC_BYTES  = 128;
	localparam int OTP_BYTES  = 64;
	localparam int PAGE_STD   = 264;
	localparam int PAGE_BIN   = 256;
	localparam int PAGE_COUNT = 4096;
	localparam int CMD_BYTES  = 4;
	localparam int MAIN_AW    = 21;
	localparam int COL_W      = 9;
	localparam int PAGE_W     = 12;
	localparam int CNT_W      = 10;
	localparam int OTP_AW     = 6;
	localparam int STD_PAGE_LSB = 9;
	localparam int BIN_PAGE_LSB = 8;
	localparam logic [CNT_W-1:0] CNT_MAX   = 10'h3FF;
	localparam logic [COL_W-1:0] OTP_LEN   = 9'h040;

	// status byte layout and fixed values
	localparam logic [7:0] OTP_BLANK    = 8'hFF;
	localparam logic [3:0] DENSITY_CODE = 4'h9;
	localparam int ST_RDY_BIT  = 7;
	localparam int ST_COMP_BIT = 6;

	typedef enum logic [2:0] {S_IDLE, S_COPY, S_CMP, S_PROG, S_OTP, S_HOLD} op_state_t;

	// longest times round down, never below one cycle
	function automatic int max_cycles(input int ns);
		int c;
		c = ns / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : max_cycles

	function automatic logic [PAGE_W-1:0] page_of(input logic [23:0] a, input logic bin);
		return bin ? a[BIN_PAGE_LSB +: PAGE_W] : a[STD_PAGE_LSB +: PAGE_W];
	endfunction : page_of

	function automatic logic [COL_W-1:0] col_of(input logic [23:0] a, input logic bin);
		return bin ? {1'b0, a[7:0]} : a[8:0];
	endfunction : col_of

	function automatic logic [COL_W-1:0] page_len(input logic bin);
		return bin ? COL_W'(PAGE_BIN) : COL_W'(PAGE_STD);
	endfunction : page_len

	// page * 264 + column, built from shifts
	function automatic logic [MAIN_AW-1:0] flat_addr(input logic [PAGE_W-1:0] p,
		input logic [COL_W-1:0] c);
		return MAIN_AW'({p, 8'h00}) + MAIN_AW'({p, 3'h0}) + MAIN_AW'(c);
	endfunction : flat_addr

	// factory half of the identification area, derived from a per-part seed
	function automatic logic [7:0] factory_byte(input logic [5:0] i, input logic [7:0] seed);
		return {2'h2, i} ^ seed;
	endfunction : factory_byte
endpackage : otp_pagebuf_pkg
`default_nettype wire

/* File: common/ram_port_if.sv */
// write and read port bundle of one byte memory
`default_nettype none
interface ram_port_if #(
	parameter int AW = 9,
	parameter int DW = 8
);
	logic          we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic          re;
	logic [AW-1:0] raddr;
	logic [DW-1:0] rdata;
	modport ram  (input we, waddr, wdata, re, raddr, output rdata);
	modport user (output we, waddr, wdata, re, raddr, input rdata);
endinterface : ram_port_if
`default_nettype wire

/* File: verilog/dual_clock_ram.sv */
// byte memory with independent write and read clocks and registered read data
`default_nettype none
module dual_clock_ram #(
	parameter int AW    = 9,
	parameter int DW    = 8,
	parameter int DEPTH = 264
) (
	// clocks
	input wire logic wclk,
	input wire logic rclk,
	// port bundle
	ram_port_if.ram  port
);
	logic [DW-1:0] mem [DEPTH];

	if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
		$error("depth does not fit the address width");
	end

	// write side
	always_ff @(posedge wclk) begin
		if (port.we) begin
			mem[port.waddr] <= port.wdata;
		end
	end

	// read data from a register; re freezes it with the owner's clock enable
	always_ff @(posedge rclk) begin
		if (port.re) begin
			port.rdata <= mem[port.raddr];
		end
	end
endmodule : dual_clock_ram
`default_nettype wire

/* File: verilog/level_sync.sv */
// two flip-flop synchroniser for slow levels
`default_nettype none
module level_sync #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and control
	input  wire logic         clk,
	input  wire logic         ce,
	input  wire logic         rst,
	// level in and out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	// the first stage feeds the second stage only
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_ff <= RST_VAL;
			q_ff    <= RST_VAL;
		end else if (ce) begin
			meta_ff <= d;
			q_ff    <= meta_ff;
		end
	end

	assign q = q_ff;
endmodule : level_sync
`default_nettype wire

/* File: verilog/otp_pagebuf_ctrl.sv */
// serial command block: identification area, page to buffer transfer, compare and rewrite
//
// Functional notes
// [RQ1] 128-byte area: 64 user, 64 factory bytes
// [RQ2] user bytes program once, never again; the code's lock (otp_done_ff) is cleared by srst, which allows another program
// [RQ3] factory bytes fixed, no command changes them
// [RQ4] user bytes programmed with no prior erase
// [RQ5] host sends 9B 00 00 00 then data
// [RQ6] program starts at select release, busy meanwhile
// [RQ7] early release leaves unsent bytes undefined
// [RQ8] more than 64 bytes wrap to zero
// [RQ9] programming uses buffer 1 as working store
// [RQ10] 77h plus three dummies reads the area
// [RQ11] select release ends read, output floats
// [RQ12] 53h/55h copy page into buffer 1/2
// [RQ13] standard pages: 3 dummy, 12 page, 9 dummy
// [RQ14] binary pages: 4 dummy, 12 page, 8 dummy
// [RQ15] transfer starts at select rise, busy meanwhile
// [RQ16] 60h/61h compare page with buffer 1/2
// [RQ17] compare while busy, result to status bit 6
// [RQ18] 58h/59h rewrite page through buffer 1/2
// [RQ19] rewrite copies page then programs it back
// [RQ20] data after rewrite address means read-modify-write
// [RQ21] host rewrites pages every 50,000 sector cycles
// [RQ22] host polls status with D7h
// [RQ23] status ready bit 0 busy, 1 ready
// [RQ24] compare flag 1 on any mismatch
// [RQ25] bytes msb first, sampled on rising clock
`default_nettype none
module otp_pagebuf_ctrl #(
	parameter int         PAGE_TRANSFER_TIME_NS = otp_pagebuf_pkg::DEF_PAGE_TRANSFER_TIME_NS,
	parameter int         PAGE_COMPARE_TIME_NS  = otp_pagebuf_pkg::DEF_PAGE_COMPARE_TIME_NS,
	parameter int         PAGE_REWRITE_TIME_NS  = otp_pagebuf_pkg::DEF_PAGE_REWRITE_TIME_NS,
	parameter int         PROGRAM_TIME_NS       = otp_pagebuf_pkg::DEF_PROGRAM_TIME_NS,
	parameter logic [7:0] FACTORY_SEED          = 8'h5A // arbitrary per-part value
) (
	// system clock and control
	input  wire logic sys_clk,
	input  wire logic srst,
	input  wire logic ce,
	// serial link
	input  wire logic spi_sck,
	input  wire logic cs_n,
	input  wire logic mosi,
	output logic      miso_o,
	output logic      miso_oe,
	// configuration and state
	input  wire logic bin_page_mode,
	output logic      busy
);
	import otp_pagebuf_pkg::*;

	localparam int TMR_W = 32;
	localparam logic [TMR_W-1:0] XFR_CYC = TMR_W'(max_cycles(PAGE_TRANSFER_TIME_NS));
	localparam logic [TMR_W-1:0] CMP_CYC = TMR_W'(max_cycles(PAGE_COMPARE_TIME_NS));
	localparam logic [TMR_W-1:0] RW_CYC  = TMR_W'(max_cycles(PAGE_REWRITE_TIME_NS));
	localparam logic [TMR_W-1:0] PRG_CYC = TMR_W'(max_cycles(PROGRAM_TIME_NS));

	if (PAGE_TRANSFER_TIME_NS < 1 || PAGE_COMPARE_TIME_NS < 1 ||
		PAGE_REWRITE_TIME_NS < 1 || PROGRAM_TIME_NS < 1) begin : g_bad_time
		$error("operation times must be positive");
	end

	// memory ports
	ram_port_if #(.AW(COL_W),   .DW(8)) stg ();
	ram_port_if #(.AW(OTP_AW),  .DW(8)) otp ();
	ram_port_if #(.AW(MAIN_AW), .DW(8)) arr ();
	ram_port_if #(.AW(COL_W),   .DW(8)) buf1 ();
	ram_port_if #(.AW(COL_W),   .DW(8)) buf2 ();

	// link-domain state
	logic [2:0]       bit_cnt_ff;
	logic [CNT_W-1:0] byte_cnt_ff;
	logic [CNT_W-1:0] frame_cnt_ff;
	logic [6:0]       sh_ff;
	logic [7:0]       op_ff;
	logic [23:0]      addr_ff;
	logic [COL_W-1:0] wr_col_ff;
	logic [6:0]       sec_idx_ff;
	logic             miso_ff;
	logic             oe_ff;

	// system-domain state
	op_state_t        st_ff;
	logic             cs_d_ff;
	logic             b2_ff;
	logic             rw_ff;
	logic             rmw_ff;
	logic [PAGE_W-1:0] page_ff;
	logic [COL_W-1:0] col_ff;
	logic [CNT_W-1:0] n_ff;
	logic [COL_W-1:0] len_ff;
	logic [COL_W-1:0] ctr_ff;
	logic             rd_v_ff;
	logic [COL_W-1:0] wcol_ff;
	logic             mism_ff;
	logic             comp_ff;
	logic             busy_ff;
	logic             otp_done_ff;
	logic [TMR_W-1:0] tmr_ff;

	// synchronised levels
	logic busy_sck, comp_sck, otp_done_sck, bin_sck;
	logic cs_sys, bin_sys;

	level_sync #(.W(4), .RST_VAL(4'h0)) u_sync_sck (
		.clk (spi_sck),
		.ce  (1'b1),
		.rst (1'b0),
		.d   ({busy_ff, comp_ff, otp_done_ff, bin_page_mode}),
		.q   ({busy_sck, comp_sck, otp_done_sck, bin_sck})
	);

	level_sync #(.W(2), .RST_VAL(2'h1)) u_sync_sys (
		.clk (sys_clk),
		.ce  (ce),
		.rst (srst),
		.d   ({bin_page_mode, cs_n}),
		.q   ({bin_sys, cs_sys})
	);

	// link-side decode
	logic [7:0]       in_byte;
	logic             byte_done, in_data, op_otp_prog, op_rw, out_active;
	logic [CNT_W-1:0] byte_cnt_nxt, data_idx;
	logic [COL_W-1:0] sck_len;
	logic [6:0]       nxt_sec_idx;
	logic [7:0]       stat_byte, sec_byte, out_byte;

	// [RQ25] msb first shift
	assign in_byte      = {sh_ff, mosi};
	assign byte_done    = (bit_cnt_ff == 3'h7);
	assign in_data      = (byte_cnt_ff >= CNT_W'(CMD_BYTES));
	assign byte_cnt_nxt = (byte_cnt_ff == CNT_MAX) ? CNT_MAX : byte_cnt_ff + 10'h001;
	assign data_idx     = byte_cnt_ff - CNT_W'(CMD_BYTES);
	assign op_otp_prog  = (op_ff == OP_OTP_PROG);
	assign op_rw        = (op_ff == OP_RW_B1) || (op_ff == OP_RW_B2);
	assign sck_len      = page_len(bin_sck);

	// frame counters clear while select is high
	always_ff @(posedge spi_sck or posedge cs_n) begin
		if (cs_n) begin
			bit_cnt_ff  <= 3'h0;
			byte_cnt_ff <= 10'h000;
		end else begin
			bit_cnt_ff  <= bit_cnt_ff + 3'h1;
			byte_cnt_ff <= byte_done ? byte_cnt_nxt : byte_cnt_ff;
		end
	end

	// command capture; kept after select rises so the system side can read it
	always_ff @(posedge spi_sck) begin
		sh_ff <= in_byte[6:0];
		if (byte_done) begin
			frame_cnt_ff <= byte_cnt_nxt;
		end else if (bit_cnt_ff == 3'h0 && byte_cnt_ff == 10'h000) begin
			frame_cnt_ff <= 10'h000;
		end
		if (byte_done && byte_cnt_ff == 10'h000) begin
			op_ff <= in_byte;
		end
		if (byte_done && byte_cnt_ff >= 10'h001 && byte_cnt_ff <= 10'h003) begin
			addr_ff <= {addr_ff[15:0], in_byte};
		end
		if (byte_done && byte_cnt_ff == 10'h003) begin
			wr_col_ff <= col_of({addr_ff[15:0], in_byte}, bin_sck);
		end else if (stg.we && !op_otp_prog) begin
			wr_col_ff <= (wr_col_ff == sck_len - 9'h001) ? 9'h000 : wr_col_ff + 9'h001;
		end
		sec_idx_ff <= nxt_sec_idx;
	end

	// data bytes land in the staging memory; writes past the page end wrap
	// [RQ8] wrap at 64
	assign stg.we    = byte_done && in_data && (op_otp_prog || op_rw);
	assign stg.waddr = op_otp_prog ? {3'h0, data_idx[5:0]} : wr_col_ff;
	assign stg.wdata = in_byte;

	// [RQ10] area read prefetch: fetch the next byte on the last bit of each byte
	assign nxt_sec_idx = byte_done ? 7'(byte_cnt_ff - 10'h003) : 7'(byte_cnt_ff - 10'h004);
	assign otp.re      = 1'b1;
	assign otp.raddr   = nxt_sec_idx[5:0];

	// [RQ1] lower half user bytes, upper half factory bytes
	// [RQ3] factory half is a constant, nothing writes it
	assign sec_byte = sec_idx_ff[6] ? factory_byte(sec_idx_ff[5:0], FACTORY_SEED) :
		(otp_done_sck ? otp.rdata : OTP_BLANK);

	// [RQ23] ready bit inverts busy
	// [RQ24] compare flag
	assign stat_byte = byte_cnt_ff[0] ?
		{~busy_sck, comp_sck, DENSITY_CODE, 1'b0, bin_sck} : {~busy_sck, 7'h00};
	assign out_byte   = (op_ff == OP_STATUS) ? stat_byte : sec_byte;
	assign out_active = ((op_ff == OP_STATUS) && byte_cnt_ff >= 10'h001) ||
		((op_ff == OP_OTP_READ) && in_data);

	// output changes on the falling edge so the host samples it on the rise
	// [RQ11] release floats output
	always_ff @(negedge spi_sck or posedge cs_n) begin
		if (cs_n) begin
			miso_ff <= 1'b0;
			oe_ff   <= 1'b0;
		end else begin
			miso_ff <= out_byte[~bit_cnt_ff];
			oe_ff   <= out_active;
		end
	end

	// gating with select covers the time before the first link edge
	assign miso_o  = miso_ff;
	assign miso_oe = oe_ff & ~cs_n;

	// system-side launch decode
	logic             cs_rise, full_cmd, is_xfr, is_cmp, is_rw, is_otp, sel_b2, go;
	logic [CNT_W-1:0] data_n;
	op_state_t        launch_st;
	logic [TMR_W-1:0] launch_tmr;

	assign cs_rise  = cs_sys & ~cs_d_ff;
	assign full_cmd = (frame_cnt_ff >= CNT_W'(CMD_BYTES));
	assign data_n   = frame_cnt_ff - CNT_W'(CMD_BYTES);
	assign is_xfr   = (op_ff == OP_XFR_B1) || (op_ff == OP_XFR_B2);
	assign is_cmp   = (op_ff == OP_CMP_B1) || (op_ff == OP_CMP_B2);
	assign is_rw    = (op_ff == OP_RW_B1) || (op_ff == OP_RW_B2);
	// [RQ5] opcode and three zero bytes
	assign is_otp   = (op_ff == OP_OTP_PROG) && (addr_ff == 24'h000000);
	assign sel_b2   = (op_ff == OP_XFR_B2) || (op_ff == OP_CMP_B2) || (op_ff == OP_RW_B2);
	// [RQ2] single program until srst clears the lock
	assign go       = full_cmd && (is_xfr || is_cmp || is_rw || (is_otp && !otp_done_ff));
	assign launch_st  = is_cmp ? S_CMP : (is_otp ? S_OTP : S_COPY);
	assign launch_tmr = is_rw ? RW_CYC - 32'h1 : is_cmp ? CMP_CYC - 32'h1 :
		is_otp ? PRG_CYC - 32'h1 : XFR_CYC - 32'h1;

	// byte walker: read at ctr, act one cycle later at wcol
	logic             active, issue, last, patched, buf_wr, otp_wr, mism_now;
	logic [COL_W-1:0] off;
	logic [7:0]       buf_rdata, copy_data;

	assign active = (st_ff == S_COPY) || (st_ff == S_CMP) || (st_ff == S_PROG) ||
		(st_ff == S_OTP);
	assign issue  = active && (ctr_ff < len_ff);
	assign last   = rd_v_ff && (wcol_ff == len_ff - 9'h001);
	assign off    = (wcol_ff >= col_ff) ? wcol_ff - col_ff : wcol_ff + len_ff - col_ff;
	// [RQ20] received bytes replace page bytes from the start column
	assign patched = rmw_ff && ((n_ff >= {1'b0, len_ff}) || ({1'b0, off} < n_ff));
	assign buf_rdata = b2_ff ? buf2.rdata : buf1.rdata;
	assign copy_data = patched ? stg.rdata : arr.rdata;
	assign buf_wr    = (st_ff == S_COPY) && rd_v_ff;
	// [RQ7] unsent bytes are left as they were
	assign otp_wr    = (st_ff == S_OTP) && rd_v_ff && ({1'b0, wcol_ff} < n_ff);
	assign mism_now  = (st_ff == S_CMP) && rd_v_ff && (arr.rdata != buf_rdata);

	// memory hookup
	assign arr.re    = ce;
	assign arr.raddr = flat_addr(page_ff, ctr_ff);
	assign arr.we    = ce && (st_ff == S_PROG) && rd_v_ff;
	assign arr.waddr = flat_addr(page_ff, wcol_ff);
	assign arr.wdata = buf_rdata;
	assign stg.re    = ce;
	assign stg.raddr = ctr_ff;
	assign buf1.re    = ce;
	assign buf1.raddr = ctr_ff;
	// [RQ9] area program also writes its bytes into buffer 1
	assign buf1.we    = ce && ((buf_wr && !b2_ff) || otp_wr);
	assign buf1.waddr = wcol_ff;
	assign buf1.wdata = (st_ff == S_OTP) ? stg.rdata : copy_data;
	assign buf2.re    = ce;
	assign buf2.raddr = ctr_ff;
	assign buf2.we    = ce && buf_wr && b2_ff;
	assign buf2.waddr = wcol_ff;
	assign buf2.wdata = copy_data;
	// [RQ4] direct write, no erase pass
	assign otp.we    = ce && otp_wr;
	assign otp.waddr = wcol_ff[OTP_AW-1:0];
	assign otp.wdata = stg.rdata;

	// operation sequencer; only an idle device accepts a new operation
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_ff       <= S_IDLE;
			cs_d_ff     <= 1'b1;
			busy_ff     <= 1'b0;
			comp_ff     <= 1'b0;
			otp_done_ff <= 1'b0;
			ctr_ff      <= 9'h000;
			rd_v_ff     <= 1'b0;
			tmr_ff      <= 32'h0;
		end else if (ce) begin
			cs_d_ff <= cs_sys;
			ctr_ff  <= issue ? ctr_ff + 9'h001 : ctr_ff;
			rd_v_ff <= issue;
			wcol_ff <= ctr_ff;
			tmr_ff  <= (tmr_ff != 32'h0) ? tmr_ff - 32'h1 : tmr_ff;
			case (st_ff)
				S_IDLE: begin
					// [RQ15] start at select rise
					// [RQ6] busy from release
					if (cs_rise && go) begin
						st_ff   <= launch_st;
						busy_ff <= 1'b1;
						b2_ff   <= sel_b2;
						rw_ff   <= is_rw;
						rmw_ff  <= is_rw && (data_n != 10'h000);
						// [RQ13] [RQ14] page field by page mode
						page_ff <= page_of(addr_ff, bin_sys);
						col_ff  <= col_of(addr_ff, bin_sys);
						n_ff    <= data_n;
						len_ff  <= is_otp ? OTP_LEN : page_len(bin_sys);
						ctr_ff  <= 9'h000;
						mism_ff <= 1'b0;
						tmr_ff  <= launch_tmr;
					end
				end
				S_COPY: begin
					// [RQ19] copy then program back
					if (last) begin
						st_ff  <= rw_ff ? S_PROG : S_HOLD;
						ctr_ff <= 9'h000;
					end
				end
				S_CMP: begin
					// [RQ17] result at end of compare
					mism_ff <= mism_ff | mism_now;
					if (last) begin
						comp_ff <= mism_ff | mism_now;
						st_ff   <= S_HOLD;
					end
				end
				S_PROG: begin
					if (last) begin
						st_ff <= S_HOLD;
					end
				end
				S_OTP: begin
					// [RQ2] lock even after a short load
					if (last) begin
						otp_done_ff <= 1'b1;
						st_ff       <= S_HOLD;
					end
				end
				S_HOLD: begin
					// self-timed length runs from launch, covering the byte walk
					if (tmr_ff == 32'h0) begin
						busy_ff <= 1'b0;
						st_ff   <= S_IDLE;
					end
				end
				default: begin
					st_ff <= S_IDLE;
				end
			endcase
		end
	end

	assign busy = busy_ff;

	// memories
	dual_clock_ram #(.AW(COL_W), .DW(8), .DEPTH(PAGE_STD)) u_stage (
		.wclk (spi_sck),
		.rclk (sys_clk),
		.port (stg)
	);

	dual_clock_ram #(.AW(OTP_AW), .DW(8), .DEPTH(OTP_BYTES)) u_otp (
		.wclk (sys_clk),
		.rclk (spi_sck),
		.port (otp)
	);

	dual_clock_ram #(.AW(MAIN_AW), .DW(8), .DEPTH(PAGE_COUNT * PAGE_STD)) u_array (
		.wclk (sys_clk),
		.rclk (sys_clk),
		.port (arr)
	);

	dual_clock_ram #(.AW(COL_W), .DW(8), .DEPTH(PAGE_STD)) u_buf1 (
		.wclk (sys_clk),
		.rclk (sys_clk),
		.port (buf1)
	);

	dual_clock_ram #(.AW(COL_W), .DW(8), .DEPTH(PAGE_STD)) u_buf2 (
		.wclk (sys_clk),
		.rclk (sys_clk),
		.port (buf2)
	);
endmodule : otp_pagebuf_ctrl
`default_nettype wire

/* File: verification/otp_pagebuf_chk.sv */
// pin-level checks of the serial command block
`default_nettype none
module otp_pagebuf_chk #(
	parameter int PAGE_TRANSFER_TIME_NS = 10000,
	parameter int PAGE_COMPARE_TIME_NS  = 10000,
	parameter int PAGE_REWRITE_TIME_NS  = 10000,
	parameter int PROGRAM_TIME_NS       = 10000
) (
	// system side
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic bin_page_mode,
	input wire logic busy,
	// link side
	input wire logic spi_sck,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso_o,
	input wire logic miso_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	// busy span bounds; the top one leaves room for a two-pass rewrite walk
	localparam int TA = PAGE_TRANSFER_TIME_NS / 10;
	localparam int TB = PAGE_COMPARE_TIME_NS / 10;
	localparam int TC = PAGE_REWRITE_TIME_NS / 10;
	localparam int TD = PROGRAM_TIME_NS / 10;
	localparam int L1 = TA < TB ? TA : TB;
	localparam int L2 = TC < TD ? TC : TD;
	localparam int H1 = TA > TB ? TA : TB;
	localparam int H2 = TC > TD ? TC : TD;
	localparam int LO = (L1 < L2 ? L1 : L2) - 3;
	localparam int HI = (H1 > H2 ? H1 : H2) + 600;
	logic [15:0] blen_ff;
	logic [15:0] nxt_blen;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);

	// length of the current busy span
	assign nxt_blen = busy ? blen_ff + 16'h0001 : 16'h0000;
	always_ff @(posedge sys_clk) begin
		if (srst)
			blen_ff <= 16'h0000;
		else
			blen_ff <= nxt_blen;
	end

	property p_oe_off; cs_n |-> !miso_oe; endproperty
	a_oe_off: assert property (p_oe_off) else $error("output driven while deselected");
	property p_busy_rst; disable iff (1'b0) srst |=> !busy; endproperty
	a_busy_rst: assert property (p_busy_rst) else $error("busy during reset");
	property p_busy_start;
		$rose(busy) |-> cs_n && $past(cs_n) && $past(cs_n, 2)
			&& (!$past(cs_n, 4) || !$past(cs_n, 5) || !$past(cs_n, 6));
	endproperty
	a_busy_start: assert property (p_busy_start) else $error("busy not tied to release");
	property p_busy_len; $fell(busy) |-> blen_ff >= LO && blen_ff <= HI; endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy span out of range");
	property p_oe_edge; $rose(miso_oe) |-> !spi_sck && !cs_n && !$past(cs_n, 100); endproperty
	a_oe_edge: assert property (p_oe_edge) else $error("output enabled too early");
	property p_miso_hold; miso_oe && spi_sck && $past(spi_sck) |-> $stable(miso_o); endproperty
	a_miso_hold: assert property (p_miso_hold) else $error("data moved while clock high");
	property p_oe_keep; miso_oe && !cs_n |=> miso_oe || cs_n; endproperty
	a_oe_keep: assert property (p_oe_keep) else $error("output dropped inside frame");
	property p_fr_start; $fell(cs_n) |-> !miso_oe; endproperty
	a_fr_start: assert property (p_fr_start) else $error("output driven at frame start");

	c_busy_rise: cover property ($rose(busy));
	c_busy_done: cover property ($fell(busy));
	c_read: cover property ($rose(miso_oe));
endmodule : otp_pagebuf_chk

bind otp_pagebuf_ctrl otp_pagebuf_chk #(
	.PAGE_TRANSFER_TIME_NS(PAGE_TRANSFER_TIME_NS),
	.PAGE_COMPARE_TIME_NS(PAGE_COMPARE_TIME_NS),
	.PAGE_REWRITE_TIME_NS(PAGE_REWRITE_TIME_NS),
	.PROGRAM_TIME_NS(PROGRAM_TIME_NS)
) otp_pagebuf_chk_i (.sys_clk(sys_clk), .srst(srst), .ce(ce), .bin_page_mode(bin_page_mode),
	.busy(busy), .spi_sck(spi_sck), .cs_n(cs_n), .mosi(mosi), .miso_o(miso_o),
	.miso_oe(miso_oe));
`default_nettype wire

/* File: verification/otp_spi_host.sv */
// serial host controller model, mode 0, clock still between frames
`default_nettype none
module otp_spi_host (
	// frame start alignment
	input  wire logic sys_clk,
	// serial link
	output logic      spi_sck,
	output logic      cs_n,
	output logic      mosi,
	input  wire logic miso_o,
	input  wire logic miso_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rx_byte;
	logic       slow_ff;
	event       got;
	// a released line shows the inverse so a stale bit never passes for data
	wire logic  miso_line = miso_oe ? miso_o : ~miso_o;

	initial begin
		spi_sck = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
		slow_ff = 1'b0;
	end

	task automatic shift(input logic [7:0] o, output logic [7:0] r);
		for (int b = 7; b >= 0; b--) begin
			mosi = o[b];
			#80 spi_sck = 1'b1;
			r = {r[6:0], miso_line};
			#80 spi_sck = 1'b0;
		end
	endtask : shift

	// whole frames; refresh pacing is the caller's
	task automatic frame(input logic [7:0] tx[$], input int nrx, input bit rep, input bit poll);
		logic [7:0] r;
		@(posedge sys_clk);
		cs_n <= 1'b0;
		#43;
		foreach (tx[i]) shift(tx[i], r);
		for (int k = 0; k < nrx; k++) begin
			shift(8'(k), r);
			rx_byte = r;
			if (rep) ->got;
			if (poll && r[7] === 1'b1) break;
		end
		#40;
		@(posedge sys_clk);
		cs_n <= 1'b1;
		// released line flips so a stale bit never looks valid
		mosi <= ~mosi;
		slow_ff <= ~slow_ff;
		// gap past the command latch, prompt or slow
		repeat (slow_ff ? 9 : 4) @(posedge sys_clk);
	endtask : frame
endmodule : otp_spi_host
`default_nettype wire

/* File: verification/otp_pagebuf_ctrl_tb.sv */
// self-checking bench for the serial command block
`default_nettype none
module otp_pagebuf_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import otp_pagebuf_pkg::*;
	localparam int         T_NS = 5000;
	localparam logic [7:0] SEED = 8'h3C; // arbitrary part seed
	logic        sys_clk;
	logic        srst;
	logic        ce;
	logic        bin_page_mode;
	logic        spi_sck;
	logic        cs_n;
	logic        mosi;
	logic        miso_o;
	logic        miso_oe;
	logic        busy;
	int          bad_count;
	int          num_checks;
	logic [7:0]  lfsr;
	logic [7:0]  b0;
	logic        c;
	logic [11:0] pg;
	logic [7:0]  od[64];
	logic [7:0]  exp_q[$];
	logic [7:0]  tx[$];

	otp_pagebuf_ctrl #(.PAGE_TRANSFER_TIME_NS(T_NS), .PAGE_COMPARE_TIME_NS(T_NS),
		.PAGE_REWRITE_TIME_NS(T_NS), .PROGRAM_TIME_NS(T_NS), .FACTORY_SEED(SEED))
		otp_pagebuf_ctrl_i (.sys_clk(sys_clk), .srst(srst), .ce(ce), .spi_sck(spi_sck),
		.cs_n(cs_n), .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe),
		.bin_page_mode(bin_page_mode), .busy(busy));
	otp_spi_host otp_spi_host_i (.sys_clk(sys_clk), .spi_sck(spi_sck), .cs_n(cs_n),
		.mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe));

	function automatic logic [7:0] rnd(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : rnd

	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected byte at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_byte

	task automatic cmp_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected busy at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_bit

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize

	// one command frame with random data; self-timed ones are polled to ready
	task automatic op(input logic [7:0] code, input logic [23:0] a, input int nd, input bit timed);
		int n;
		tx = '{code, a[23:16], a[15:8], a[7:0]};
		for (n = 0; n < nd; n++) begin
			lfsr = rnd(lfsr);
			tx.push_back(lfsr);
		end
		otp_spi_host_i.frame(tx, 0, 1'b0, 1'b0);
		if (!timed) repeat (8) @(posedge sys_clk);
		n = 0;
		while (timed && busy !== 1'b1 && n < 8) begin
			@(posedge sys_clk);
			n++;
		end
		cmp_bit(busy, timed);
		if (timed) otp_spi_host_i.frame('{OP_STATUS}, 60, 1'b0, 1'b1);
		cmp_bit(busy, 1'b0);
	endtask : op

	task automatic status(input logic [7:0] e);
		exp_q.push_back(e);
		otp_spi_host_i.frame('{OP_STATUS}, 1, 1'b1, 1'b0);
	endtask : status

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// oldest note meets each byte the host reports
	initial begin
		forever begin
			@(otp_spi_host_i.got);
			cmp_byte(otp_spi_host_i.rx_byte, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
		end
	end

	// hang guard, about one and a half times the planned run, still inside the cycle budget
	initial begin
		#950000;
		bad_count++;
		summarize();
	end

	initial begin
		srst = 1'b1;
		ce = 1'b1;
		bin_page_mode = 1'b0;
		bad_count = 0;
		num_checks = 0;
		lfsr = 8'h0F;
		repeat (12) @(posedge sys_clk);
		srst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		cmp_bit(busy, 1'b0);
		// both bytes of status in both page modes
		for (int m = 0; m < 2; m++) begin
			bin_page_mode <= m[0];
			repeat (4) @(posedge sys_clk);
			exp_q.push_back({7'h52, m[0]});
			exp_q.push_back(8'h80);
			otp_spi_host_i.frame('{OP_STATUS}, 2, 1'b1, 1'b0);
		end
		$display("test status done");
		bin_page_mode <= 1'b0;
		exp_q.push_back(8'hFF);
		exp_q.push_back(8'hFF);
		otp_spi_host_i.frame('{OP_OTP_READ, 8'h00, 8'h00, 8'h00}, 2, 1'b1, 1'b0);
		op(OP_OTP_PROG, 24'h000000, 65, 1'b1);
		for (int i = 0; i < 64; i++) od[i] = tx[4 + i];
		od[0] = tx[68];
		// a second program must leave the area alone
		op(OP_OTP_PROG, 24'h000000, 2, 1'b0);
		for (int i = 0; i < 66; i++)
			exp_q.push_back(i < 64 ? od[i] : {2'h2, 6'(i)} ^ SEED);
		otp_spi_host_i.frame('{OP_OTP_READ, 8'h00, 8'h00, 8'h00}, 66, 1'b1, 1'b0);
		$display("test area done");
		lfsr = rnd(lfsr);
		pg = {lfsr[3:0], lfsr};
		op(OP_XFR_B1, {3'h0, pg, 9'h000}, 0, 1'b1);
		bin_page_mode <= 1'b1;
		repeat (4) @(posedge sys_clk);
		op(OP_RW_B1, {4'h0, pg, 8'h00}, 256, 1'b1);
		b0 = tx[4];
		op(OP_CMP_B1, {4'h0, pg, 8'h00}, 0, 1'b1);
		status(8'hA5);
		op(OP_RW_B2, {4'h0, pg, 8'h00}, 1, 1'b1);
		c = tx[4] !== b0;
		op(OP_CMP_B1, {4'h0, pg, 8'h00}, 0, 1'b1);
		status({1'b1, c, 6'h25});
		op(OP_XFR_B2, {4'h0, pg, 8'h00}, 0, 1'b1);
		op(OP_CMP_B2, {4'h0, pg, 8'h00}, 0, 1'b1);
		status(8'hA5);
		$display("test page ops done");
		cmp_bit(exp_q.size() == 0, 1'b1);
		summarize();
	end
endmodule : otp_pagebuf_ctrl_tb
`default_nettype wire
